// ---- src/boundary_scan_tap.sv ----
// Boundary-scan test access port: controller, instruction and data regs
//
// Contract
// R01 - Controller advances on test clock rising edge
// R02 - Power-up: reset state, identification instruction
// R03 - Select-DR: low capture, high select-IR
// R04 - Capture-DR loads selected register, then branches
// R05 - Shift-DR shifts selected register toward output
// R06 - Exit1/Exit2-DR branch to update, pause, shift
// R07 - Pause states hold until mode select high
// R08 - Update-DR falling edge copies to latches
// R09 - Select-IR: low capture, high reset
// R10 - Capture-IR loads fixed value into stage
// R11 - Shift-IR shifts instruction stage only
// R12 - Exit-IR states go update when high
// R13 - Update-IR falling edge latches new instruction
// R14 - Three-bit instruction: shift stage plus latch
// R15 - Code 010 samples and preloads boundary
// R16 - Code 111 puts bypass bit in path
// R17 - Code 000 drives pins from boundary latches
// R18 - Code 011 clamps outputs, bypass in path
// R19 - Code 100 floats outputs, bypass in path
// R20 - Code 001 captures and shifts identification
// R21 - Reset state forces identification as current
// R22 - Identification layout: one, maker, part, revision
// R23 - Identification: 32-bit stage plus latched output
// R24 - Five high edges always reach reset
// R25 - Low test reset forces reset state
`timescale 1ns/100ps
`include "tap_defines.svh"
module boundary_scan_tap
#(
    parameter logic [3:0]  REVISION   = 4'h0,     // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0001, // Arbitrary value
    parameter logic [10:0] MAKER_CODE = 11'h001   // Arbitrary value
)
(
    // System clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    RESET_N,
    // Test access pins
    input  wire logic                    TEST_RESET_N,
    input  wire logic                    TEST_CLOCK,
    input  wire logic                    TEST_MODE_SELECT,
    input  wire logic                    TEST_DATA_IN,
    output logic                         TEST_DATA_OUT,
    output logic                         TEST_DATA_OUT_OE,
    // Boundary cells facing device pins
    input  wire logic [`BSR_LEN-1:0]     PIN_SAMPLE,
    output logic      [`BSR_LEN-1:0]     PIN_DRIVE,
    output logic                         PIN_TEST_MODE,
    output logic                         PIN_HIGHZ,
    // Status
    output logic      [`IR_WIDTH-1:0]    CURRENT_OP,
    output tap_pkg::tap_state_type       TAP_STATE
);
    import tap_pkg::*;

    localparam logic [`ID_WIDTH-1:0] ID_CODE =
        {REVISION, PART_CODE, MAKER_CODE, 1'b1};   // R22

    tap_pins_type                 pins;
    tap_events_type               ev;
    tap_state_type                state_q;
    tap_state_type                state_d;
    tap_state_type                step_next;
    logic [`IR_WIDTH-1:0]         ir_shift_q;
    logic [`IR_WIDTH-1:0]         ir_q;
    logic                         bypass_q;
    logic [`ID_WIDTH-1:0]         id_shift_q;
    logic [`ID_WIDTH-1:0]         id_latch_q;
    logic [`BSR_LEN-1:0]          bsr_shift_q;
    logic [`BSR_LEN-1:0]          bsr_latch_q;
    logic                         tdo_q;
    logic                         oe_q;
    logic                         drive_q;
    logic                         highz_q;

    assign pins = '{test_reset_n:     TEST_RESET_N,
                    test_clock:       TEST_CLOCK,
                    test_mode_select: TEST_MODE_SELECT,
                    test_data_in:     TEST_DATA_IN};

    tap_sync u_sync (
        .clk     (CLK_SYS),
        .reset_n (RESET_N),
        .pins    (pins),
        .events  (ev)
    );

    tap_next u_next (
        .state (state_q),
        .tms   (ev.tms),
        .next  (step_next)
    );

    // Instruction decode
    wire sel_bsr  = (ir_q == `OP_SAMPLE) || (ir_q == `OP_EXTEST); // R15 R17
    wire sel_id   = (ir_q == `OP_IDCODE);                          // R20
    wire sel_byp  = !sel_bsr && !sel_id;               // R16 R18 R19
    wire in_reset = !ev.trst_n || (state_q == TEST_RESET);
    wire rise     = ev.rise && ev.trst_n;
    wire fall     = ev.fall && ev.trst_n;
    wire do_cap_dr = rise && (state_q == CAP_DR);
    wire do_sh_dr  = rise && (state_q == SHIFT_DR);
    wire do_cap_ir = rise && (state_q == CAP_IR);
    wire do_sh_ir  = rise && (state_q == SHIFT_IR);
    wire do_upd_dr = fall && (state_q == UPD_DR);
    wire do_upd_ir = fall && (state_q == UPD_IR);
    wire shifting  = (state_q == SHIFT_DR) || (state_q == SHIFT_IR);
    wire dr_out    = sel_bsr ? bsr_shift_q[0] :
                     sel_id  ? id_shift_q[0]  : bypass_q;
    wire tdo_d     = (state_q == SHIFT_IR) ? ir_shift_q[0] : dr_out;
    wire [`IR_WIDTH-1:0] ir_d = in_reset  ? `OP_IDCODE :           // R21
                                do_upd_ir ? ir_shift_q : ir_q;     // R13
    wire drive_d   = (ir_q == `OP_EXTEST) || (ir_q == `OP_CLAMP);  // R17 R18
    wire highz_d   = (ir_q == `OP_HIGHZ);                          // R19

    // Test reset pin overrides the controller
    always_comb begin
        state_d = state_q;
        if (!ev.trst_n)
            state_d = TEST_RESET;                                  // R25
        else if (ev.rise)
            state_d = step_next;                                   // R01
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            state_q <= TEST_RESET;                                 // R02
            ir_q    <= `OP_IDCODE;                                 // R02
        end else begin
            state_q <= state_d;
            ir_q    <= ir_d;                                       // R14
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            ir_shift_q <= `IR_CAPTURE;
        else if (do_cap_ir)
            ir_shift_q <= `IR_CAPTURE;                             // R10
        else if (do_sh_ir)
            ir_shift_q <= {ev.tdi, ir_shift_q[`IR_WIDTH-1:1]};     // R11
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            bypass_q <= 1'b0;
        else if (sel_byp && do_cap_dr)
            bypass_q <= 1'b0;
        else if (sel_byp && do_sh_dr)
            bypass_q <= ev.tdi;                                    // R16
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            id_shift_q <= 32'h0000_0000;
        else if (sel_id && do_cap_dr)
            id_shift_q <= ID_CODE;                                 // R20
        else if (sel_id && do_sh_dr)
            id_shift_q <= {ev.tdi, id_shift_q[`ID_WIDTH-1:1]};     // R05
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            id_latch_q <= 32'h0000_0000;
        else if (sel_id && do_upd_dr)
            id_latch_q <= id_shift_q;                              // R23
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            bsr_shift_q <= 8'h00;
        else if (sel_bsr && do_cap_dr)
            bsr_shift_q <= PIN_SAMPLE;                             // R04 R15
        else if (sel_bsr && do_sh_dr)
            bsr_shift_q <= {ev.tdi, bsr_shift_q[`BSR_LEN-1:1]};    // R05
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N)
            bsr_latch_q <= 8'h00;
        else if (sel_bsr && do_upd_dr)
            bsr_latch_q <= bsr_shift_q;                            // R08
    end

    // Output changes on the test clock falling edge
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            tdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else if (!ev.trst_n) begin
            oe_q  <= 1'b0;
        end else if (ev.fall) begin
            tdo_q <= tdo_d;
            oe_q  <= shifting;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            drive_q <= 1'b0;
            highz_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            highz_q <= highz_d;
        end
    end

    assign TEST_DATA_OUT    = tdo_q;
    assign TEST_DATA_OUT_OE = oe_q;
    assign PIN_DRIVE        = bsr_latch_q;
    assign PIN_TEST_MODE    = drive_q;
    assign PIN_HIGHZ        = highz_q;
    assign CURRENT_OP       = ir_q;
    assign TAP_STATE        = state_q;

    // Checks
    logic [2:0] high_cnt_q;
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N || !ev.trst_n)
            high_cnt_q <= 3'h0;
        else if (ev.rise)
            high_cnt_q <= ev.tms ? ((high_cnt_q == 3'h5) ? 3'h5 :
                                    high_cnt_q + 3'h1) : 3'h0;
    end

    a_five_high_reset: assert property (@(posedge CLK_SYS) // R24
        disable iff (!RESET_N) high_cnt_q == 3'h5 |-> state_q == TEST_RESET)
        else $error("five high edges did not reach reset");
    a_trst_forces: assert property (@(posedge CLK_SYS) // R25
        disable iff (!RESET_N) !ev.trst_n |=> state_q == TEST_RESET)
        else $error("test reset did not force reset state");
    a_state_on_rise: assert property (@(posedge CLK_SYS) // R01
        disable iff (!RESET_N) (ev.trst_n && !ev.rise) |=> $stable(state_q))
        else $error("state changed without rising edge");
    a_reset_idcode: assert property (@(posedge CLK_SYS) // R21
        disable iff (!RESET_N) state_q == TEST_RESET |=> ir_q == `OP_IDCODE)
        else $error("reset state without identification instruction");
    a_seldr_branch: assert property (@(posedge CLK_SYS) // R03
        disable iff (!RESET_N) (rise && state_q == SEL_DR)
        |=> state_q == ($past(ev.tms) ? SEL_IR : CAP_DR))
        else $error("bad branch from select-dr");
    a_capir_value: assert property (@(posedge CLK_SYS) // R10
        disable iff (!RESET_N) do_cap_ir |=> ir_shift_q == `IR_CAPTURE)
        else $error("capture-ir did not load fixed value");
    a_id_capture: assert property (@(posedge CLK_SYS) // R20
        disable iff (!RESET_N) (sel_id && do_cap_dr) |=> id_shift_q == ID_CODE)
        else $error("identification not captured");
    a_ir_hold: assert property (@(posedge CLK_SYS) // R11
        disable iff (!RESET_N) (state_q == SHIFT_IR && ev.trst_n)
        |=> $stable(ir_q))
        else $error("current instruction moved during shift-ir");
    a_update_ir: assert property (@(posedge CLK_SYS) // R13
        disable iff (!RESET_N) do_upd_ir |=> ir_q == $past(ir_shift_q))
        else $error("update-ir did not latch instruction");
    a_bsr_latch: assert property (@(posedge CLK_SYS) // R08
        disable iff (!RESET_N) (state_q != UPD_DR) |=> $stable(bsr_latch_q))
        else $error("boundary latch changed outside update-dr");
    a_pause_hold: assert property (@(posedge CLK_SYS) // R07
        disable iff (!RESET_N) (state_q == PAUSE_DR) |=> $stable(id_shift_q))
        else $error("shift stage moved during pause");
    a_pause_ir_hold: assert property (@(posedge CLK_SYS) // R07
        disable iff (!RESET_N) (state_q == PAUSE_IR && ev.trst_n)
        |=> $stable(ir_shift_q) && $stable(ir_q))
        else $error("instruction moved during pause-ir");
    a_seldr_hold: assert property (@(posedge CLK_SYS) // R03
        disable iff (!RESET_N) (state_q == SEL_DR)
        |=> $stable(id_shift_q) && $stable(bsr_shift_q)
            && $stable(bypass_q))
        else $error("test register moved in select-dr");
    a_selir_hold: assert property (@(posedge CLK_SYS) // R09
        disable iff (!RESET_N) (state_q == SEL_IR && ev.trst_n)
        |=> $stable(ir_q) && $stable(ir_shift_q))
        else $error("instruction moved in select-ir");
    a_id_shift_in: assert property (@(posedge CLK_SYS) // R05
        disable iff (!RESET_N) (sel_id && do_sh_dr)
        |=> id_shift_q[`ID_WIDTH-1] == $past(ev.tdi))
        else $error("identification stage did not take input bit");
    a_bsr_shift_in: assert property (@(posedge CLK_SYS) // R05
        disable iff (!RESET_N) (sel_bsr && do_sh_dr)
        |=> bsr_shift_q[`BSR_LEN-1] == $past(ev.tdi))
        else $error("boundary stage did not take input bit");
    a_ir_shift_in: assert property (@(posedge CLK_SYS) // R11
        disable iff (!RESET_N) do_sh_ir
        |=> ir_shift_q[`IR_WIDTH-1] == $past(ev.tdi))
        else $error("instruction stage did not take input bit");
    a_exit1dr_branch: assert property (@(posedge CLK_SYS) // R06
        disable iff (!RESET_N) (rise && state_q == EXIT1_DR)
        |=> state_q == ($past(ev.tms) ? UPD_DR : PAUSE_DR))
        else $error("bad branch from exit1-dr");
    a_exit2ir_branch: assert property (@(posedge CLK_SYS) // R12
        disable iff (!RESET_N) (rise && state_q == EXIT2_IR)
        |=> state_q == ($past(ev.tms) ? UPD_IR : SHIFT_IR))
        else $error("bad branch from exit2-ir");
    a_id_latch: assert property (@(posedge CLK_SYS) // R23
        disable iff (!RESET_N) (sel_id && do_upd_dr)
        |=> id_latch_q == $past(id_shift_q))
        else $error("identification latch not loaded");
    a_clamp_steady: assert property (@(posedge CLK_SYS) // R18
        disable iff (!RESET_N) (ir_q == `OP_CLAMP) |=> $stable(bsr_latch_q))
        else $error("boundary latch moved under clamp");
    a_float_mode: assert property (@(posedge CLK_SYS) // R19
        disable iff (!RESET_N) (ir_q == `OP_HIGHZ) |=> PIN_HIGHZ)
        else $error("outputs not floated");
    a_drive_mode: assert property (@(posedge CLK_SYS) // R17
        disable iff (!RESET_N) (ir_q == `OP_EXTEST) |=> PIN_TEST_MODE)
        else $error("outputs not driven from boundary latch");
endmodule

// ---- src/tap_defines.svh ----
// Constants for the boundary-scan test access port
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH
`define IR_WIDTH        3
`define IR_CAPTURE      3'h1
`define OP_EXTEST       3'h0
`define OP_IDCODE       3'h1
`define OP_SAMPLE       3'h2
`define OP_CLAMP        3'h3
`define OP_HIGHZ        3'h4
`define OP_BYPASS       3'h7
`define ID_WIDTH        32
`define ID_REV_LSB      28
`define ID_PART_LSB     12
`define ID_MAKER_LSB    1
`define BSR_LEN         8
`endif

// ---- src/tap_pkg.sv ----
// Types for the boundary-scan test access port
package tap_pkg;
    typedef enum logic [3:0] {
        TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR,
        PAUSE_DR, EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR,
        EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_type;
    typedef struct packed {
        logic test_reset_n;
        logic test_clock;
        logic test_mode_select;
        logic test_data_in;
    } tap_pins_type;
    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_events_type;
endpackage

// ---- src/tap_sync.sv ----
// Two-stage synchroniser and edge finder for the test pins
`timescale 1ns/100ps
module tap_sync
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Pins and events
    input  wire tap_pkg::tap_pins_type  pins,
    output tap_pkg::tap_events_type     events
);
    import tap_pkg::*;

    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       clk_last_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q     <= 4'h9;
            sync_q     <= 4'h9;
            clk_last_q <= 1'b0;
        end else begin
            meta_q     <= pins;
            sync_q     <= meta_q;
            clk_last_q <= sync_q[2];
        end
    end

    assign events.trst_n = sync_q[3];
    assign events.rise   = sync_q[2] & ~clk_last_q;
    assign events.fall   = ~sync_q[2] & clk_last_q;
    assign events.tms    = sync_q[1];
    assign events.tdi    = sync_q[0];
endmodule

// ---- src/tap_next.sv ----
// Next-state table of the test access port controller
`timescale 1ns/100ps
module tap_next
(
    // State and select level
    input  tap_pkg::tap_state_type  state,
    input  wire logic               tms,
    // Next state
    output tap_pkg::tap_state_type  next
);
    import tap_pkg::*;

    always_comb begin
        next = state;
        unique case (state)
            TEST_RESET: next = tms ? TEST_RESET : RUN_IDLE;  // R24
            RUN_IDLE:   next = tms ? SEL_DR : RUN_IDLE;      // R24
            SEL_DR:     next = tms ? SEL_IR : CAP_DR;        // R03
            CAP_DR:     next = tms ? EXIT1_DR : SHIFT_DR;    // R04
            SHIFT_DR:   next = tms ? EXIT1_DR : SHIFT_DR;    // R05
            EXIT1_DR:   next = tms ? UPD_DR : PAUSE_DR;      // R06
            PAUSE_DR:   next = tms ? EXIT2_DR : PAUSE_DR;    // R07
            EXIT2_DR:   next = tms ? UPD_DR : SHIFT_DR;      // R06
            UPD_DR:     next = tms ? SEL_DR : RUN_IDLE;
            SEL_IR:     next = tms ? TEST_RESET : CAP_IR;    // R09
            CAP_IR:     next = tms ? EXIT1_IR : SHIFT_IR;    // R10
            SHIFT_IR:   next = tms ? EXIT1_IR : SHIFT_IR;    // R11
            EXIT1_IR:   next = tms ? UPD_IR : PAUSE_IR;      // R12
            PAUSE_IR:   next = tms ? EXIT2_IR : PAUSE_IR;    // R07
            EXIT2_IR:   next = tms ? UPD_IR : SHIFT_IR;      // R12
            UPD_IR:     next = tms ? SEL_DR : RUN_IDLE;      // R13
        endcase
    end
endmodule

// ---- verification/tap_tester.sv ----
// Behavioural boundary-scan tester that drives the test access pins
`timescale 1ns/100ps
module tap_tester (
    // Pins toward the device
    output logic      trst_n,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Serial answer
    input  wire logic tdo
);
    initial begin
        trst_n = 1'b1;
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b0;
    end

    // One 125 ns test clock period; the clock rests low between calls
    task automatic cycle(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #62.5;
        q = tdo;
        tck <= 1'b1;
        #62.5;
        tck <= 1'b0;
    endtask

    // Low pulse well beyond the synchroniser depth
    task automatic pulse_reset();
        trst_n <= 1'b0;
        #200;
        trst_n <= 1'b1;
        #100;
    endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
`include "tap_defines.svh"
module tb_top;
    import tap_pkg::*;
    localparam logic [31:0] ID = {4'h5, 16'hc3a1, 11'h2b5, 1'b1};
    logic          clk_sys    = 1'b0;
    logic          reset_n    = 1'b0;
    logic [7:0]    pin_sample = 8'h00;
    logic          trst_n, tck, tms, tdi, tdo, tdo_oe;
    logic          pin_test_mode, pin_highz;
    logic [7:0]    pin_drive;
    logic [2:0]    current_op;
    tap_state_type tap_state;
    int            miscompares = 0;
    int            comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    boundary_scan_tap #(
        .REVISION   (4'h5),     // Arbitrary value
        .PART_CODE  (16'hc3a1), // Arbitrary value
        .MAKER_CODE (11'h2b5)   // Arbitrary value
    ) boundary_scan_tap_inst (
        .CLK_SYS          (clk_sys),
        .RESET_N          (reset_n),
        .TEST_RESET_N     (trst_n),
        .TEST_CLOCK       (tck),
        .TEST_MODE_SELECT (tms),
        .TEST_DATA_IN     (tdi),
        .TEST_DATA_OUT    (tdo),
        .TEST_DATA_OUT_OE (tdo_oe),
        .PIN_SAMPLE       (pin_sample),
        .PIN_DRIVE        (pin_drive),
        .PIN_TEST_MODE    (pin_test_mode),
        .PIN_HIGHZ        (pin_highz),
        .CURRENT_OP       (current_op),
        .TAP_STATE        (tap_state)
    );

    tap_tester tap_tester_inst (
        .trst_n (trst_n),
        .tck    (tck),
        .tms    (tms),
        .tdi    (tdi),
        .tdo    (tdo)
    );

    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic go(input logic m);
        logic q;
        tap_tester_inst.cycle(m, 1'b0, q);
    endtask

    // From idle: capture, shift n bits LSB first, update, back to idle
    task automatic dr_scan(input logic [39:0] din, input int n,
                           output logic [39:0] dout);
        logic q;
        dout = '0;
        go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++) begin
            tap_tester_inst.cycle(i == n - 1, din[i], q);
            dout[i] = q;
            if (i == 1) check(tdo_oe === 1'b1, "oe in shift");
        end
        go(1'b1);
        go(1'b0);
    endtask

    task automatic ir_scan(input logic [2:0] code);
        logic [2:0] cap;
        go(1'b1);
        go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < 3; i++) begin
            tap_tester_inst.cycle(i == 2, code[i], cap[i]);
        end
        check(cap === `IR_CAPTURE, "ir capture");
        go(1'b1);
        go(1'b0);
        check(current_op === code, "instruction latch");
    endtask

    task automatic read_id();
        logic [39:0] q;
        dr_scan(40'h0, 32, q);
        check(q[31:0] === ID, "id code");
    endtask

    task automatic walk_states();
        logic [24:0] seq = 25'b1001010010111101001011111;
        tap_state_type exp [25] = '{TEST_RESET, RUN_IDLE, RUN_IDLE, SEL_DR,
            CAP_DR, EXIT1_DR, PAUSE_DR, PAUSE_DR, EXIT2_DR, SHIFT_DR,
            EXIT1_DR, UPD_DR, SEL_DR, SEL_IR, CAP_IR, EXIT1_IR, PAUSE_IR,
            PAUSE_IR, EXIT2_IR, SHIFT_IR, EXIT1_IR, UPD_IR, SEL_DR, SEL_IR,
            TEST_RESET};
        for (int i = 0; i < 25; i++) begin
            go(seq[24-i]);
            check(tap_state === exp[i], "walk");
        end
    endtask

    task automatic test_codes();
        logic [39:0] q;
        logic [2:0]  ops [3] = '{`OP_CLAMP, `OP_BYPASS, `OP_HIGHZ};
        @(posedge clk_sys);
        pin_sample <= 8'h3c;
        ir_scan(`OP_SAMPLE);
        dr_scan(40'h5a96, 16, q);
        check(q[15:0] === 16'h963c, "sample path");
        check(pin_test_mode === 1'b0, "sample mode");
        @(posedge clk_sys);
        pin_sample <= 8'hc5;
        ir_scan(`OP_EXTEST);
        check(pin_test_mode === 1'b1, "extest mode");
        dr_scan(40'h1e77, 16, q);
        check(q[15:0] === 16'h77c5, "extest path");
        check(pin_drive === 8'h1e, "boundary latch");
        ir_scan(`OP_IDCODE);
        read_id();
        foreach (ops[i]) begin
            ir_scan(ops[i]);
            check(pin_test_mode === (i == 0), "clamp mode");
            check(pin_highz === (i == 2), "float mode");
            dr_scan(40'ha5, 8, q);
            check(q[7:0] === 8'h4a, "bypass path");
            check(pin_drive === 8'h1e, "latch held");
        end
    endtask

    task automatic reset_state();
        check(tap_state === TEST_RESET, "reset state");
        check(current_op === `OP_IDCODE, "reset op");
        check(tdo_oe === 1'b0, "reset oe");
    endtask

    // From idle into Shift-DR, then five high edges
    task automatic five_high();
        go(1'b1);
        go(1'b0);
        go(1'b0);
        repeat (5) go(1'b1);
        check(tap_state === TEST_RESET, "five high");
        check(current_op === `OP_IDCODE, "forced op");
        check(pin_highz === 1'b0, "float released");
    endtask

    // Test reset pulse while parked in Shift-DR under bypass
    task automatic async_reset();
        go(1'b0);
        ir_scan(`OP_BYPASS);
        go(1'b1);
        go(1'b0);
        go(1'b0);
        tap_tester_inst.pulse_reset();
        check(tap_state === TEST_RESET, "async reset");
        check(current_op === `OP_IDCODE, "async op");
        check(tdo_oe === 1'b0, "async oe");
    endtask

    initial begin
        #900000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset_state();
        walk_states();
        go(1'b0);
        read_id();
        test_codes();
        five_high();
        async_reset();
        print_verdict();
    end
endmodule
